// *** verilog/gcsf_defines.svh ***
`ifndef GCSF_DEFINES_SVH
`define GCSF_DEFINES_SVH
`define GCSF_CTRL_OFS 12'h000
`define GCSF_STAT_OFS 12'h004
`define GCSF_CTRL_SEL 0
`define GCSF_CTRL_GATE 1
`define GCSF_CTRL_LVL 2
`define GCSF_CTRL_SLEEPN 3
`define GCSF_CTRL_FORCE 4
`define GCSF_CTRL_W 5
`define GCSF_CTRL_RST 5'h0B
`define GCSF_STAT_SRC 0
`define GCSF_STAT_ENA 1
`define GCSF_STAT_ENB 2
`define GCSF_STAT_BUSY 3
`define GCSF_STAT_W 4
`define GCSF_SYNC_STAGES 2
`define GCSF_OUTS 4
`endif

// *** verilog/gcsf_pkg.sv ***
`include "gcsf_defines.svh"
package gcsf_pkg;
    typedef logic [31:0] gcsf_word_t;
    typedef logic [`GCSF_CTRL_W-1:0] gcsf_ctrl_t;
    typedef logic [`GCSF_STAT_W-1:0] gcsf_stat_t;
endpackage

// *** verilog/gcsf_top.sv ***
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "gcsf_defines.svh"

module gcsf_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic [`GCSF_SYNC_STAGES-1:0] s_r;
    logic [`GCSF_SYNC_STAGES-1:0] s_nxt;
    always_comb begin
        s_nxt = {s_r[`GCSF_SYNC_STAGES-2:0], d};
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign q = s_r[`GCSF_SYNC_STAGES-1];
endmodule

module gcsf_top #(
    parameter int ADDR_W = 12,
    parameter int OUTS = `GCSF_OUTS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output gcsf_pkg::gcsf_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic first_clock_input,
    input wire logic second_clock_input,
    output logic [OUTS-1:0] clk_out,
    output logic [OUTS-1:0] clk_out_n
);
    gcsf_pkg::gcsf_ctrl_t ctrl_r;
    gcsf_pkg::gcsf_ctrl_t ctrl_nxt;
    gcsf_pkg::gcsf_word_t prdata_r;
    gcsf_pkg::gcsf_word_t prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic force_d_r;
    logic kill_a_r;
    logic kill_b_r;
    logic kill_a_nxt;
    logic kill_b_nxt;
    logic force_rise;
    logic sel_r;
    logic gate_r;
    logic lvl_r;
    logic sleep_n_r;
    logic force_r;
    logic wr_en;
    logic hit_ctrl;
    logic hit_stat;
    logic st_a;
    logic st_b;
    logic rst_a_n;
    logic rst_b_n;
    logic rst_a_s_n;
    logic rst_b_s_n;
    logic sel_a_s;
    logic enb_a_s;
    logic sel_b_s;
    logic ena_b_s;
    logic en_a_r;
    logic en_b_r;
    logic en_a_nxt;
    logic en_b_nxt;
    logic mux_clk;
    gcsf_pkg::gcsf_stat_t stat;

    assign sel_r = ctrl_r[`GCSF_CTRL_SEL];
    assign gate_r = ctrl_r[`GCSF_CTRL_GATE];
    assign lvl_r = ctrl_r[`GCSF_CTRL_LVL];
    assign sleep_n_r = ctrl_r[`GCSF_CTRL_SLEEPN];
    assign force_r = ctrl_r[`GCSF_CTRL_FORCE];
    assign hit_ctrl = paddr == ADDR_W'(`GCSF_CTRL_OFS);
    assign hit_stat = paddr == ADDR_W'(`GCSF_STAT_OFS);
    assign wr_en = psel && penable && pready_r && pwrite && hit_ctrl;
    assign force_rise = force_r && !force_d_r;

    // Status seen from the bus clock
    always_comb begin
        stat = '0;
        stat[`GCSF_STAT_SRC] = st_a;
        stat[`GCSF_STAT_ENA] = st_a;
        stat[`GCSF_STAT_ENB] = st_b;
        stat[`GCSF_STAT_BUSY] = (st_a != sel_r) || (st_b == sel_r);
    end

    // Bus slave with one wait-free access phase
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_en) begin
            ctrl_nxt = pwdata[`GCSF_CTRL_W-1:0];
        end
        pready_nxt = psel && !penable;
        pslverr_nxt = psel && !penable && !hit_ctrl && !hit_stat;
        prdata_nxt = '0;
        if (psel && !penable && hit_ctrl) begin
            prdata_nxt = 32'(ctrl_r);
        end else if (psel && !penable && hit_stat) begin
            prdata_nxt = 32'(stat);
        end
    end

    // Forced choice drops the unchosen side at once
    always_comb begin
        kill_a_nxt = 1'b0;
        kill_b_nxt = 1'b0;
        if (force_rise) begin
            kill_a_nxt = !sel_r;
            kill_b_nxt = sel_r;
        end else if (force_r) begin
            kill_a_nxt = kill_a_r;
            kill_b_nxt = kill_b_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `GCSF_CTRL_RST;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            force_d_r <= 1'b0;
            kill_a_r <= 1'b0;
            kill_b_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            force_d_r <= force_r;
            kill_a_r <= kill_a_nxt;
            kill_b_r <= kill_b_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Sleep and forced kill clear a side asynchronously
    assign rst_a_n = presetn && sleep_n_r && !kill_a_r;
    assign rst_b_n = presetn && sleep_n_r && !kill_b_r;

    // Side resets assert at once and release on the side's own clock
    gcsf_sync u_rst_a (.clk(first_clock_input), .rst_n(rst_a_n),
        .d(1'b1), .q(rst_a_s_n));
    gcsf_sync u_rst_b (.clk(second_clock_input), .rst_n(rst_b_n),
        .d(1'b1), .q(rst_b_s_n));
    gcsf_sync u_sel_a (.clk(first_clock_input), .rst_n(rst_a_s_n),
        .d(sel_r), .q(sel_a_s));
    gcsf_sync u_enb_a (.clk(first_clock_input), .rst_n(rst_a_s_n),
        .d(en_b_r), .q(enb_a_s));
    // Second side syncs its own choice, so reset means not chosen
    gcsf_sync u_sel_b (.clk(second_clock_input), .rst_n(rst_b_s_n),
        .d(!sel_r), .q(sel_b_s));
    gcsf_sync u_ena_b (.clk(second_clock_input), .rst_n(rst_b_s_n),
        .d(en_a_r), .q(ena_b_s));
    gcsf_sync u_st_a (.clk(pclk), .rst_n(presetn), .d(en_a_r),
        .q(st_a));
    gcsf_sync u_st_b (.clk(pclk), .rst_n(presetn), .d(en_b_r),
        .q(st_b));

    // Each side enables only when chosen and the other side is off
    always_comb begin
        en_a_nxt = sel_a_s && !enb_a_s;
        en_b_nxt = sel_b_s && !ena_b_s;
    end

    // Enables change while their own clock is low
    always_ff @(negedge first_clock_input or negedge rst_a_s_n) begin
        if (!rst_a_s_n) begin
            en_a_r <= 1'b0;
        end else begin
            en_a_r <= en_a_nxt;
        end
    end

    always_ff @(negedge second_clock_input or negedge rst_b_s_n) begin
        if (!rst_b_s_n) begin
            en_b_r <= 1'b0;
        end else begin
            en_b_r <= en_b_nxt;
        end
    end

    assign mux_clk = (first_clock_input && en_a_r) ||
        (second_clock_input && en_b_r);

    // Output stage: sleep over gate over clock
    always_comb begin
        if (!sleep_n_r) begin
            clk_out = '1;
            clk_out_n = '1;
        end else if (gate_r) begin
            clk_out = {OUTS{lvl_r}};
            clk_out_n = {OUTS{!lvl_r}};
        end else begin
            clk_out = {OUTS{mux_clk}};
            clk_out_n = {OUTS{!mux_clk}};
        end
    end

    property p_excl;
        @(posedge pclk) disable iff (!presetn) !(en_a_r && en_b_r);
    endproperty
    a_excl: assert property (p_excl)
        else $error("both sources enabled");

    property p_sleep;
        @(posedge pclk) disable iff (!presetn)
            !sleep_n_r |-> (clk_out == '1) && (clk_out_n == '1);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep outputs not high");

    property p_gate;
        @(posedge pclk) disable iff (!presetn)
            sleep_n_r && gate_r |-> clk_out == {OUTS{lvl_r}};
    endproperty
    a_gate: assert property (p_gate)
        else $error("gated true level wrong");

    property p_gate_n;
        @(posedge pclk) disable iff (!presetn)
            sleep_n_r && gate_r |-> clk_out_n == {OUTS{!lvl_r}};
    endproperty
    a_gate_n: assert property (p_gate_n)
        else $error("gated complement level wrong");

    property p_fanout;
        @(posedge pclk) disable iff (!presetn)
            sleep_n_r && !gate_r |->
            clk_out == {OUTS{clk_out[0]}} && clk_out_n == ~clk_out;
    endproperty
    a_fanout: assert property (p_fanout)
        else $error("outputs differ");

    property p_route_a;
        @(posedge pclk) disable iff (!presetn)
            sleep_n_r && !gate_r && en_a_r |->
            clk_out[0] == first_clock_input;
    endproperty
    a_route_a: assert property (p_route_a)
        else $error("first clock not routed");

    property p_route_b;
        @(posedge pclk) disable iff (!presetn)
            sleep_n_r && !gate_r && en_b_r |->
            clk_out[0] == second_clock_input;
    endproperty
    a_route_b: assert property (p_route_b)
        else $error("second clock not routed");

    property p_force;
        @(posedge pclk) disable iff (!presetn)
            $rose(force_r) |=> (kill_a_r == !sel_r) && (kill_b_r == sel_r)
            ##1 (sel_r ? !en_b_r : !en_a_r);
    endproperty
    a_force: assert property (p_force)
        else $error("forced choice not taken");

    property p_kill;
        @(posedge pclk) disable iff (!presetn)
            kill_b_r |=> !en_b_r;
    endproperty
    a_kill: assert property (p_kill)
        else $error("killed side still enabled");

    property p_kill_a;
        @(posedge pclk) disable iff (!presetn)
            kill_a_r |=> !en_a_r;
    endproperty
    a_kill_a: assert property (p_kill_a)
        else $error("killed first side still enabled");

    property p_switch;
        @(posedge pclk) disable iff (!presetn || !sleep_n_r)
            $changed(sel_r) |-> ##[1:400] (st_a == sel_r);
    endproperty
    a_switch: assert property (p_switch)
        else $error("switchover did not finish");

    c_to_a: cover property (@(posedge pclk) $rose(en_a_r));
    c_to_b: cover property (@(posedge pclk) $rose(en_b_r));
    c_force: cover property (@(posedge pclk) $rose(kill_a_r));
    c_gate: cover property (@(posedge pclk) $fell(gate_r));
endmodule

// *** verif/gcsf_clk_src.sv ***
`timescale 1ns/100ps
module gcsf_clk_src (
    input wire logic run_first,
    input wire logic run_second,
    output logic first_clock_input,
    output logic second_clock_input
);
    // A halted source freezes at its last level, like a dead reference
    initial begin
        first_clock_input = 1'b0;
        #3;
        forever begin
            #80;
            if (run_first) begin
                first_clock_input = ~first_clock_input;
            end
        end
    end

    initial begin
        second_clock_input = 1'b0;
        #47;
        forever begin
            #80;
            if (run_second) begin
                second_clock_input = ~second_clock_input;
            end
        end
    end
endmodule

// *** verif/gcsf_top_bench.sv ***
`timescale 1ns/100ps
module gcsf_top_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    gcsf_pkg::gcsf_word_t prdata;
    logic pready, pslverr, fclk, sclk, er;
    logic run_f = 1'b1;
    logic run_s = 1'b1;
    logic [3:0] clk_out, clk_out_n;
    logic watch = 1'b0;
    logic runt = 1'b0;
    logic stall = 1'b0;
    logic [31:0] rd;
    int err_count = 0;
    int check_count = 0;
    time t_last = 0;

    gcsf_top i_gcsf_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .first_clock_input(fclk),
        .second_clock_input(sclk), .clk_out(clk_out),
        .clk_out_n(clk_out_n));
    gcsf_clk_src i_gcsf_clk_src (.run_first(run_f), .run_second(run_s),
        .first_clock_input(fclk), .second_clock_input(sclk));

    initial begin
        forever #10 pclk = ~pclk;
    end

    // Flags runt phases and overlong dead time while a switch is watched
    always @(clk_out[0]) begin
        if (watch && $time - t_last < 80) begin
            runt = 1'b1;
        end
        if (watch && clk_out[0] && $time - t_last > 1120) begin
            stall = 1'b1;
        end
        t_last = $time;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                       input logic ee);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, er}, {31'h0, ee});
    endtask

    task automatic wstat(input logic [31:0] e);
        int i = 0;
        apb(1'b0, 12'h004, 32'h0);
        while (rd !== e && i < 300) begin
            apb(1'b0, 12'h004, 32'h0);
            i++;
        end
        chk(rd, e);
    endtask

    task automatic outs(input logic [7:0] e);
        @(negedge pclk);
        chk({24'h0, clk_out, clk_out_n}, {24'h0, e});
    endtask

    task automatic follow(input logic f);
        logic s;
        repeat (24) begin
            @(negedge pclk);
            s = f ? fclk : sclk;
            chk({24'h0, clk_out, clk_out_n}, {24'h0, {4{s}}, {4{~s}}});
        end
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h000, 32'h0B, 1'b0);
        outs(8'h0F);
        rdc(12'h010, 32'h0, 1'b1);
        wstat(32'h3);
        apb(1'b1, 12'h004, 32'hF);
        rdc(12'h004, 32'h3, 1'b0);
        apb(1'b1, 12'h000, 32'h0F);
        outs(8'hF0);
        // Gate changes land inside a low phase of the active clock
        @(negedge fclk);
        apb(1'b1, 12'h000, 32'h09);
        follow(1'b1);
        watch = 1'b1;
        apb(1'b1, 12'h000, 32'h08);
        rdc(12'h004, 32'hB, 1'b0);
        wstat(32'h4);
        follow(1'b0);
        apb(1'b1, 12'h000, 32'h09);
        wstat(32'h3);
        follow(1'b1);
        watch = 1'b0;
        chk({31'h0, runt}, 32'h0);
        chk({31'h0, stall}, 32'h0);
        run_f <= 1'b0;
        apb(1'b1, 12'h000, 32'h08);
        apb(1'b1, 12'h000, 32'h18);
        wstat(32'h4);
        follow(1'b0);
        apb(1'b1, 12'h000, 32'h08);
        run_f <= 1'b1;
        @(negedge sclk);
        apb(1'b1, 12'h000, 32'h0A);
        outs(8'h0F);
        apb(1'b1, 12'h000, 32'h02);
        outs(8'hFF);
        apb(1'b1, 12'h000, 32'h0A);
        wstat(32'h4);
        @(negedge sclk);
        apb(1'b1, 12'h000, 32'h08);
        follow(1'b0);
        wrap_up;
    end

    initial begin
        #1000000;
        err_count++;
        wrap_up;
    end
endmodule
